// ### hw/fpe_map.svh
// constants for the frequency protection elements
`ifndef FPE_MAP_SVH
`define FPE_MAP_SVH
`define FPE_NLEV 6
`define FPE_FREQ_W 16
`define FPE_VOLT_W 16
`define FPE_DLY_W 16
`define FPE_EN_W 3
`define FPE_ROW_W 8
`define FPE_ROW_TPO 6
`define FPE_ROW_BAUX 7
`define FPE_CLK_NS 50
`define FPE_DLY_UNIT_NS 1000000
`define FPE_TICK_CYCLES (`FPE_DLY_UNIT_NS / `FPE_CLK_NS)
`define FPE_TICK_W 16
`endif

// ### hw/fpe_pkg.sv
// types shared by the frequency protection elements
`include "fpe_map.svh"
package fpe_pkg;
   typedef struct packed {
      logic [`FPE_VOLT_W-1:0] va;
      logic [`FPE_VOLT_W-1:0] vb;
      logic [`FPE_VOLT_W-1:0] vc;
   } fpe_volt_t;
   typedef struct packed {
      logic [`FPE_FREQ_W-1:0] pickup;
      logic [`FPE_DLY_W-1:0] delay;
   } fpe_level_cfg_t;
endpackage

// ### hw/fpe_top.sv
// over/underfrequency protection levels with undervoltage block and timers
`timescale 1ns/1ps
`include "fpe_map.svh"
module fpe_top import fpe_pkg::*; #(
   parameter int TICK_CYCLES = `FPE_TICK_CYCLES
) (
   input wire logic ref_clk,
   input wire logic rstn,
   input wire logic [`FPE_FREQ_W-1:0] meas_freq,
   input wire fpe_volt_t phase_volt,
   input wire logic [`FPE_FREQ_W-1:0] nominal_frequency_setting,
   input wire logic [`FPE_VOLT_W-1:0] freq_undervoltage_block_threshold,
   input wire logic [`FPE_EN_W-1:0] freq_level_count_enable,
   input wire fpe_level_cfg_t [`FPE_NLEV-1:0] level_cfg,
   input wire logic [`FPE_NLEV-1:0] contact_select,
   input wire logic three_pole_open_flag,
   input wire logic breaker_aux_contact_flag,
   output logic [`FPE_NLEV-1:0] freq_level_pickup_bits,
   output logic [`FPE_NLEV-1:0] freq_level_timed_out,
   output logic [`FPE_ROW_W-1:0] status_row14,
   output logic output_contact
);
   localparam int NLEV = `FPE_NLEV;

   // the prescaler counter is FPE_TICK_W bits wide and must count at least once
   generate
      if (TICK_CYCLES < 1 || TICK_CYCLES >= (1 << `FPE_TICK_W)) begin : g_bad_tick
         $error("TICK_CYCLES out of range");
      end
   endgenerate

   // delay unit prescaler; free running, so a delay is exact to within one unit
   logic [`FPE_TICK_W-1:0] tick_cnt;
   logic [`FPE_TICK_W-1:0] next_tick_cnt;
   logic tick;

   always_comb begin
      tick = (tick_cnt == `FPE_TICK_W'(TICK_CYCLES - 1));
      next_tick_cnt = tick ? '0 : tick_cnt + `FPE_TICK_W'(1);
   end

   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         tick_cnt <= '0;
      end else begin
         tick_cnt <= next_tick_cnt;
      end
   end

   // any single phase under threshold blocks every level
   logic uv_block;
   always_comb begin
      uv_block = (phase_volt.va < freq_undervoltage_block_threshold) ||
                 (phase_volt.vb < freq_undervoltage_block_threshold) ||
                 (phase_volt.vc < freq_undervoltage_block_threshold);
   end

   logic [NLEV-1:0] next_pick;
   logic [NLEV-1:0] next_timed;
   logic [`FPE_DLY_W-1:0] dly_cnt [NLEV];
   logic [`FPE_DLY_W-1:0] next_dly_cnt [NLEV];

   genvar gi;
   generate
      for (gi = 0; gi < NLEV; gi++) begin : g_lev
         logic is_under;
         logic is_over;
         logic active;
         logic [31:0] held_cyc;
         logic [31:0] next_held_cyc;
         always_comb begin
            is_under = level_cfg[gi].pickup < nominal_frequency_setting;
            is_over = level_cfg[gi].pickup > nominal_frequency_setting;
            active = (freq_level_count_enable > `FPE_EN_W'(gi));
            // a pickup equal to nominal is neither under nor over and never operates
            next_pick[gi] = active && !uv_block &&
                            ((is_under && meas_freq < level_cfg[gi].pickup) ||
                             (is_over && meas_freq > level_cfg[gi].pickup));
            if (!freq_level_pickup_bits[gi]) begin
               next_dly_cnt[gi] = '0;
            end else if (tick && dly_cnt[gi] < level_cfg[gi].delay) begin
               next_dly_cnt[gi] = dly_cnt[gi] + `FPE_DLY_W'(1);
            end else begin
               next_dly_cnt[gi] = dly_cnt[gi];
            end
            next_timed[gi] = next_pick[gi] && freq_level_pickup_bits[gi] &&
                             (dly_cnt[gi] >= level_cfg[gi].delay);
         end

         always_ff @(posedge ref_clk or negedge rstn) begin
            if (!rstn) begin
               dly_cnt[gi] <= '0;
            end else begin
               dly_cnt[gi] <= next_dly_cnt[gi];
            end
         end

         // checker aid: cycles the pickup has stood; saturates so a long pickup cannot wrap
         always_comb begin
            if (!freq_level_pickup_bits[gi]) begin
               next_held_cyc = '0;
            end else if (held_cyc != 32'hFFFFFFFF) begin
               next_held_cyc = held_cyc + 32'h00000001;
            end else begin
               next_held_cyc = held_cyc;
            end
         end

         always_ff @(posedge ref_clk or negedge rstn) begin
            if (!rstn) begin
               held_cyc <= '0;
            end else begin
               held_cyc <= next_held_cyc;
            end
         end

         // the free running prescaler may shorten a delay by up to one unit, never lengthen it
         property p_timed_due;
            @(posedge ref_clk) disable iff (!rstn)
            freq_level_pickup_bits[gi] && next_pick[gi] &&
            (held_cyc >= 32'(level_cfg[gi].delay) * 32'(TICK_CYCLES))
            |=> freq_level_timed_out[gi];
         endproperty
         a_timed_due: assert property (p_timed_due) else $error("timed bit late");

         property p_under;
            @(posedge ref_clk) disable iff (!rstn)
            (is_under && active && !uv_block && meas_freq < level_cfg[gi].pickup)
            |=> freq_level_pickup_bits[gi];
         endproperty
         a_under: assert property (p_under) else $error("underfrequency pickup missed");

         property p_over;
            @(posedge ref_clk) disable iff (!rstn)
            (is_over && active && !uv_block && meas_freq > level_cfg[gi].pickup)
            |=> freq_level_pickup_bits[gi];
         endproperty
         a_over: assert property (p_over) else $error("overfrequency pickup missed");

         property p_enable;
            @(posedge ref_clk) disable iff (!rstn)
            !active |=> !freq_level_pickup_bits[gi] && !freq_level_timed_out[gi];
         endproperty
         a_enable: assert property (p_enable) else $error("disabled level operated");

         property p_follow;
            @(posedge ref_clk) disable iff (!rstn)
            !((is_under && meas_freq < level_cfg[gi].pickup) ||
              (is_over && meas_freq > level_cfg[gi].pickup)) |=> !freq_level_pickup_bits[gi];
         endproperty
         a_follow: assert property (p_follow) else $error("pickup did not drop");

         sequence s_timed_rise;
            !freq_level_timed_out[gi] ##1 freq_level_timed_out[gi];
         endsequence
         property p_timed;
            @(posedge ref_clk) disable iff (!rstn)
            s_timed_rise |-> $past(freq_level_pickup_bits[gi]) &&
                             $past(dly_cnt[gi]) >= $past(level_cfg[gi].delay);
         endproperty
         a_timed: assert property (p_timed) else $error("timed bit early");

         property p_restart;
            @(posedge ref_clk) disable iff (!rstn)
            !freq_level_pickup_bits[gi] |=> dly_cnt[gi] == '0;
         endproperty
         a_restart: assert property (p_restart) else $error("timer not restarted");

         property p_drop;
            @(posedge ref_clk) disable iff (!rstn)
            !freq_level_pickup_bits[gi] |-> !freq_level_timed_out[gi];
         endproperty
         a_drop: assert property (p_drop) else $error("timed bit without pickup");

         // judged against the raw inputs, so a timed path that bypasses the pickup is caught
         property p_drop_now;
            @(posedge ref_clk) disable iff (!rstn)
            (uv_block || !active ||
             !((is_under && meas_freq < level_cfg[gi].pickup) ||
               (is_over && meas_freq > level_cfg[gi].pickup))) |=> !freq_level_timed_out[gi];
         endproperty
         a_drop_now: assert property (p_drop_now) else $error("timed bit held");
      end
   endgenerate

   logic [`FPE_ROW_W-1:0] next_row;
   logic next_contact;
   always_comb begin
      next_row = '0;
      next_row[NLEV-1:0] = next_pick;
      next_row[`FPE_ROW_TPO] = three_pole_open_flag;
      next_row[`FPE_ROW_BAUX] = breaker_aux_contact_flag;
      next_contact = |(next_pick & contact_select);
   end

   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         freq_level_pickup_bits <= '0;
         freq_level_timed_out <= '0;
         status_row14 <= '0;
         output_contact <= 1'b0;
      end else begin
         freq_level_pickup_bits <= next_pick;
         freq_level_timed_out <= next_timed;
         status_row14 <= next_row;
         output_contact <= next_contact;
      end
   end

   property p_block;
      @(posedge ref_clk) disable iff (!rstn)
      uv_block |=> freq_level_pickup_bits == '0 && freq_level_timed_out == '0;
   endproperty
   a_block: assert property (p_block) else $error("undervoltage block ignored");

   property p_row;
      @(posedge ref_clk) disable iff (!rstn)
      ##1 status_row14 == {$past(breaker_aux_contact_flag), $past(three_pole_open_flag),
                           freq_level_pickup_bits};
   endproperty
   a_row: assert property (p_row) else $error("status row mismatch");

   property p_contact;
      @(posedge ref_clk) disable iff (!rstn)
      ##1 output_contact == |(freq_level_pickup_bits & $past(contact_select));
   endproperty
   a_contact: assert property (p_contact) else $error("contact mismatch");
endmodule

// ### tb/fpe_front_model.sv
// behavioural measurement front end feeding frequency and phase magnitudes
`timescale 1ns/1ps
`include "fpe_map.svh"
module fpe_front_model import fpe_pkg::*; (
   input wire logic [`FPE_FREQ_W-1:0] freq_cmd,
   input wire fpe_volt_t volt_cmd,
   output logic [`FPE_FREQ_W-1:0] meas_freq,
   output fpe_volt_t phase_volt
);
   // settles at once; a real front end lags by its averaging window, the relay must not care
   assign meas_freq = freq_cmd;
   assign phase_volt = volt_cmd;
endmodule

// ### tb/fpe_top_bench.sv
// self-checking bench for the frequency protection elements
`timescale 1ns/1ps
`include "fpe_map.svh"
module fpe_top_bench import fpe_pkg::*; ;
   logic ref_clk = 1'b0;
   logic rstn = 1'b0;
   logic [15:0] freq_cmd = 16'h1000;
   fpe_volt_t volt_cmd = '{16'h0800, 16'h0800, 16'h0800};
   logic [15:0] meas_freq;
   fpe_volt_t phase_volt;
   logic [2:0] count_en = 3'h6;
   logic [15:0] nominal_set = 16'h1000;
   logic [15:0] uv_thr = 16'h0400;
   fpe_level_cfg_t [`FPE_NLEV-1:0] cfg;
   logic [5:0] csel = 6'h01;
   logic tpo = 1'b0;
   logic baux = 1'b0;
   logic [5:0] pick;
   logic [5:0] timed;
   logic [7:0] row;
   logic contact;
   int failures = 0;
   int n_tests = 0;
   int cycles = 0;
   always #25 ref_clk = ~ref_clk;
   fpe_front_model i_front (.freq_cmd(freq_cmd), .volt_cmd(volt_cmd), .meas_freq(meas_freq),
      .phase_volt(phase_volt));
   fpe_top #(.TICK_CYCLES(4)) i_dut (.ref_clk(ref_clk), .rstn(rstn), .meas_freq(meas_freq),
      .phase_volt(phase_volt), .nominal_frequency_setting(nominal_set),
      .freq_undervoltage_block_threshold(uv_thr), .freq_level_count_enable(count_en),
      .level_cfg(cfg), .contact_select(csel), .three_pole_open_flag(tpo),
      .breaker_aux_contact_flag(baux), .freq_level_pickup_bits(pick),
      .freq_level_timed_out(timed), .status_row14(row), .output_contact(contact));
   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      n_tests++;
      if (seen !== exp) begin
         failures++;
         $display("[FAIL] %0d ns: saw %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic cyc(input int n);
      repeat (n) @(negedge ref_clk);
   endtask
   task automatic tally_and_finish;
      $display("comparisons %0d mismatches %0d", n_tests, failures);
      if (failures == 0 && n_tests > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask
   task automatic t_under;
      freq_cmd = 16'h0E00;
      cyc(1);
      check({2'h0, pick}, 8'h01);
      check(row, 8'h01);
      check({7'h0, contact}, 8'h01);
      cyc(1);
      check({2'h0, timed}, 8'h01);
      freq_cmd = 16'h1000;
      cyc(1);
      check({5'h00, pick[0], timed[0], contact}, 8'h00);
   endtask
   task automatic t_over;
      freq_cmd = 16'h1200;
      cyc(1);
      check({2'h0, pick}, 8'h02);
      cyc(6);
      check({2'h0, timed}, 8'h00);
      freq_cmd = 16'h1000;
      cyc(1);
      freq_cmd = 16'h1200;
      // the short dropout must throw away the time already served
      cyc(7);
      check({2'h0, timed}, 8'h00);
      cyc(8);
      check({2'h0, timed}, 8'h02);
      check({7'h0, contact}, 8'h00);
   endtask
   task automatic t_block;
      volt_cmd.vb = 16'h03FF;
      cyc(1);
      check({2'h0, pick}, 8'h00);
      check({2'h0, timed}, 8'h00);
      volt_cmd.vb = 16'h0400;
      cyc(1);
      check({2'h0, pick}, 8'h02);
      count_en = 3'h1;
      tpo = 1'b1;
      baux = 1'b1;
      cyc(1);
      check(row, 8'hC0);
      freq_cmd = 16'h1000;
      count_en = 3'h6;
   endtask
   task automatic t_modes;
      // nominal below the level 0 pickup turns that level into an overfrequency one
      nominal_set = 16'h0E80;
      cyc(1);
      check({2'h0, pick}, 8'h01);
      check(row, 8'hC1);
      check({7'h0, contact}, 8'h01);
      count_en = 3'h0;
      cyc(1);
      check({2'h0, pick}, 8'h00);
      nominal_set = 16'h1000;
      count_en = 3'h6;
   endtask
   always @(posedge ref_clk) begin
      cycles <= cycles + 1;
      if (cycles == 2000) begin
         failures++;
         tally_and_finish();
      end
   end
   initial begin
      for (int i = 0; i < `FPE_NLEV; i++) begin
         cfg[i] = '{pickup: 16'h1000, delay: 16'h0000};
      end
      cfg[0].pickup = 16'h0F00;
      cfg[1] = '{pickup: 16'h1100, delay: 16'h0002};
      cyc(4);
      check({row[5:0], pick[1:0]}, 8'h00);
      cyc(1);
      rstn = 1'b1;
      cyc(2);
      t_under;
      t_over;
      t_block;
      t_modes;
      tally_and_finish();
   end
endmodule
